// ===== src/ahs_axis_homing_sequencer.sv
// Homing sequencer for one axis: modes 29, 30, 33, 34, 35.
// Assumes sensors arrive asynchronously from the drive; one clock domain.
`timescale 1ns/1ps

module ahs_axis_homing_sequencer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HOMING_COMMAND, // One-cycle start pulse, same domain
  input wire logic [5:0] HOME_MODE, // Mode selector, same domain
  input wire logic [31:0] AXIS_POS, // Present axis position, same domain
  input wire logic HOME_SW, // Home switch pin, asynchronous
  input wire logic NEG_LIMIT, // Negative limit pin, asynchronous
  input wire logic INDEX_PULSE, // Encoder index pin, asynchronous
  output logic MOVE, // Motion commanded
  output logic DIR, // 1 positive, 0 negative
  output logic PHASE, // 0 first-phase, 1 second-phase speed
  output logic [31:0] ORIGIN, // Latched home position
  output logic DONE // Home latched, held until next valid command
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [2:0] home_q; // Home switch sync chain
  logic [2:0] lim_q; // Limit sync chain
  logic [2:0] idx_q; // Index sync chain
  logic home_f_q; // Filtered home level
  logic lim_f_q; // Filtered limit level
  logic idx_f_q; // Filtered index level
  logic idx_prev_q; // Index level one cycle ago
  logic home_prev_q; // Home level one cycle ago

  // Three-stage chains
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      home_q <= 3'h0;
      lim_q <= 3'h0;
      idx_q <= 3'h0;
    end else begin
      home_q <= {home_q[1:0], HOME_SW};
      lim_q <= {lim_q[1:0], NEG_LIMIT};
      idx_q <= {idx_q[1:0], INDEX_PULSE};
    end
  end

  // Level accepted once stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      home_f_q <= 1'b0;
      lim_f_q <= 1'b0;
      idx_f_q <= 1'b0;
      home_prev_q <= 1'b0;
      idx_prev_q <= 1'b0;
    end else begin
      home_f_q <= (home_q[1] == home_q[2]) ? home_q[2] : home_f_q;
      lim_f_q <= (lim_q[1] == lim_q[2]) ? lim_q[2] : lim_f_q;
      idx_f_q <= (idx_q[1] == idx_q[2]) ? idx_q[2] : idx_f_q;
      home_prev_q <= home_f_q;
      idx_prev_q <= idx_f_q;
    end
  end

  // Edge strobes on filtered levels
  logic home_rise;
  logic home_fall;
  logic idx_rise;
  assign home_rise = home_f_q && !home_prev_q;
  assign home_fall = !home_f_q && home_prev_q;
  assign idx_rise = idx_f_q && !idx_prev_q;

  // ==========================================================
  // Sequencer
  // ==========================================================
  ahs_pkg::ahs_state_type state_q; // Current state
  logic [5:0] mode_q; // Mode captured at command
  logic latch; // Home event this cycle

  // Mode decode of captured and presented modes
  logic cmd_valid;
  assign cmd_valid = (HOME_MODE == ahs_pkg::MODE_SW_NEG_A) ||
                     (HOME_MODE == ahs_pkg::MODE_SW_NEG_B) ||
                     (HOME_MODE == ahs_pkg::MODE_IDX_NEG) ||
                     (HOME_MODE == ahs_pkg::MODE_IDX_POS) ||
                     (HOME_MODE == ahs_pkg::MODE_HERE);

  logic is29;
  assign is29 = (mode_q == ahs_pkg::MODE_SW_NEG_A);

  // Latch condition per state and mode
  always_comb begin
    latch = 1'b0;
    unique case (state_q)
      ahs_pkg::ST_SEEK: begin
        if (mode_q == ahs_pkg::MODE_IDX_NEG ||
            mode_q == ahs_pkg::MODE_IDX_POS) begin
          latch = idx_rise;
        end else begin
          // Mode 29 after the limit reversal latches on switch on
          latch = is29 && DIR == ahs_pkg::DIR_POS && home_rise;
        end
      end
      ahs_pkg::ST_CROSS: begin
        latch = !is29 && home_fall;
      end
      ahs_pkg::ST_RETURN: begin
        latch = is29 ? home_rise : home_fall;
      end
      ahs_pkg::ST_IDLE, ahs_pkg::ST_DONE: latch = 1'b0;
    endcase
  end

  // State, direction and phase updates
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ahs_pkg::ST_IDLE;
      mode_q <= 6'h0_0;
      DIR <= ahs_pkg::DIR_NEG;
      PHASE <= ahs_pkg::PHASE_FIRST;
    end else if (HOMING_COMMAND && cmd_valid) begin
      mode_q <= HOME_MODE;
      PHASE <= ahs_pkg::PHASE_SECOND;
      DIR <= ahs_pkg::DIR_NEG;
      if (HOME_MODE == ahs_pkg::MODE_HERE) begin
        state_q <= ahs_pkg::ST_DONE;
      end else if (HOME_MODE == ahs_pkg::MODE_IDX_NEG) begin
        state_q <= ahs_pkg::ST_SEEK;
      end else if (HOME_MODE == ahs_pkg::MODE_IDX_POS) begin
        state_q <= ahs_pkg::ST_SEEK;
        DIR <= ahs_pkg::DIR_POS;
      end else if (home_f_q) begin
        // Switch already on: straight to second phase, negative
        state_q <= ahs_pkg::ST_CROSS;
      end else begin
        state_q <= ahs_pkg::ST_SEEK;
        PHASE <= ahs_pkg::PHASE_FIRST;
      end
    end else if (latch) begin
      state_q <= ahs_pkg::ST_DONE;
    end else begin
      unique case (state_q)
        ahs_pkg::ST_SEEK: begin
          // Index modes only watch the index; switch modes ignore it
          if (mode_q == ahs_pkg::MODE_SW_NEG_A ||
              mode_q == ahs_pkg::MODE_SW_NEG_B) begin
            if (DIR == ahs_pkg::DIR_NEG && lim_f_q && !home_f_q) begin
              DIR <= ahs_pkg::DIR_POS;
            end else if (home_rise) begin
              PHASE <= ahs_pkg::PHASE_SECOND;
              if (DIR == ahs_pkg::DIR_POS) begin
                // Mode 30 after the limit reversal; mode 29 has latched
                DIR <= ahs_pkg::DIR_NEG;
                state_q <= ahs_pkg::ST_CROSS;
              end else begin
                state_q <= ahs_pkg::ST_CROSS;
              end
            end
          end
        end
        ahs_pkg::ST_CROSS: begin
          // Mode 29 reverses on leaving the switch
          if (is29 && home_fall) begin
            DIR <= ahs_pkg::DIR_POS;
            state_q <= ahs_pkg::ST_RETURN;
          end
        end
        ahs_pkg::ST_RETURN, ahs_pkg::ST_IDLE, ahs_pkg::ST_DONE: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Motion while seeking, crossing or returning
  assign MOVE = (state_q == ahs_pkg::ST_SEEK) ||
                (state_q == ahs_pkg::ST_CROSS) ||
                (state_q == ahs_pkg::ST_RETURN);

  // Origin load and done flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ORIGIN <= ahs_pkg::ORIGIN_RST;
      DONE <= 1'b0;
    end else if (HOMING_COMMAND && cmd_valid) begin
      DONE <= (HOME_MODE == ahs_pkg::MODE_HERE);
      if (HOME_MODE == ahs_pkg::MODE_HERE) begin
        ORIGIN <= AXIS_POS;
      end
    end else if (latch) begin
      ORIGIN <= AXIS_POS;
      DONE <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_here_done;
    @(posedge CLK) disable iff (!RST_N)
      (HOMING_COMMAND && HOME_MODE == ahs_pkg::MODE_HERE)
      |=> (DONE && !MOVE && ORIGIN == $past(AXIS_POS));
  endproperty
  a_here_done: assert property (p_here_done)
    else $error("mode 35 did not latch at once");

  property p_rsvd;
    @(posedge CLK) disable iff (!RST_N)
      (HOMING_COMMAND && !MOVE &&
       (HOME_MODE == ahs_pkg::MODE_RSVD_A ||
        HOME_MODE == ahs_pkg::MODE_RSVD_B)) |=>
      (!MOVE && DONE == $past(DONE));
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved mode started motion");

  property p_idx_neg;
    @(posedge CLK) disable iff (!RST_N)
      (HOMING_COMMAND && HOME_MODE == ahs_pkg::MODE_IDX_NEG)
      |=> (MOVE && DIR == ahs_pkg::DIR_NEG && PHASE);
  endproperty
  a_idx_neg: assert property (p_idx_neg)
    else $error("mode 33 start wrong");

  property p_idx_pos;
    @(posedge CLK) disable iff (!RST_N)
      (HOMING_COMMAND && HOME_MODE == ahs_pkg::MODE_IDX_POS)
      |=> (MOVE && DIR == ahs_pkg::DIR_POS && PHASE);
  endproperty
  a_idx_pos: assert property (p_idx_pos)
    else $error("mode 34 start wrong");

  property p_start_sw;
    @(posedge CLK) disable iff (!RST_N)
      (HOMING_COMMAND && (HOME_MODE == ahs_pkg::MODE_SW_NEG_A ||
       HOME_MODE == ahs_pkg::MODE_SW_NEG_B)) |=>
      (PHASE == $past(home_f_q) && DIR == ahs_pkg::DIR_NEG);
  endproperty
  a_start_sw: assert property (p_start_sw)
    else $error("start phase not chosen from switch");

  property p_done_stop;
    @(posedge CLK) disable iff (!RST_N)
      DONE |-> !MOVE;
  endproperty
  a_done_stop: assert property (p_done_stop)
    else $error("motion while done");

  property p_sw_ignore_idx;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == ahs_pkg::ST_SEEK && !HOMING_COMMAND && idx_rise &&
       (is29 || mode_q == ahs_pkg::MODE_SW_NEG_B) && !home_rise) |=> !DONE;
  endproperty
  a_sw_ignore_idx: assert property (p_sw_ignore_idx)
    else $error("index pulse latched in switch mode");

  property p_m29_rev;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == ahs_pkg::ST_CROSS && is29 && home_fall &&
       !HOMING_COMMAND) |=> (DIR == ahs_pkg::DIR_POS && PHASE && MOVE);
  endproperty
  a_m29_rev: assert property (p_m29_rev)
    else $error("mode 29 did not reverse");

  property p_m30_latch;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == ahs_pkg::ST_CROSS && !is29 && home_fall &&
       !HOMING_COMMAND) |=> (DONE && ORIGIN == $past(AXIS_POS));
  endproperty
  a_m30_latch: assert property (p_m30_latch)
    else $error("mode 30 did not latch on switch off");

  // Main scenarios
  c_m29: cover property (@(posedge CLK) disable iff (!RST_N)
    state_q == ahs_pkg::ST_RETURN ##[1:200] DONE);
  c_m30: cover property (@(posedge CLK) disable iff (!RST_N)
    !is29 && state_q == ahs_pkg::ST_CROSS ##1 DONE);
  c_idx: cover property (@(posedge CLK) disable iff (!RST_N)
    idx_rise && state_q == ahs_pkg::ST_SEEK);
  c_lim: cover property (@(posedge CLK) disable iff (!RST_N)
    state_q == ahs_pkg::ST_SEEK && DIR == ahs_pkg::DIR_POS);

endmodule

// ===== src/ahs_pkg.sv
// Package for the axis homing sequencer: modes, phases, widths, reset values.
// Assumes a single controller clock; no software-visible registers.
package ahs_pkg;

  // Widths
  localparam int MODE_W = 6;
  localparam int POS_W = 32;

  // Homing mode values handled here
  localparam logic [5:0] MODE_SW_NEG_A = 6'h1_D;
  localparam logic [5:0] MODE_SW_NEG_B = 6'h1_E;
  localparam logic [5:0] MODE_RSVD_A = 6'h1_F;
  localparam logic [5:0] MODE_RSVD_B = 6'h2_0;
  localparam logic [5:0] MODE_IDX_NEG = 6'h2_1;
  localparam logic [5:0] MODE_IDX_POS = 6'h2_2;
  localparam logic [5:0] MODE_HERE = 6'h2_3;

  // Direction encoding
  localparam logic DIR_POS = 1'b1;
  localparam logic DIR_NEG = 1'b0;

  // Speed phase encoding
  localparam logic PHASE_FIRST = 1'b0;
  localparam logic PHASE_SECOND = 1'b1;

  // Reset values
  localparam logic [31:0] ORIGIN_RST = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,   // Waiting for a homing command
    ST_SEEK,   // First leg toward the switch or index
    ST_CROSS,  // Inside the switch, moving negative, waiting for its lower edge
    ST_RETURN, // Reversed, waiting for the switch edge that latches
    ST_DONE    // Home latched
  } ahs_state_type;

endpackage

// ===== verification/ahs_axis_homing_sequencer_bench.sv
// Self-checking bench for the homing sequencer with an axis model.
// Assumes the sequencer and ahs_axis_model; one 100 MHz clock.
`timescale 1ns/1ps

module ahs_axis_homing_sequencer_bench;
  // ==========================================
  // Signals
  typedef struct {
    logic [31:0] edge_pos; // Expected latch point
    logic [4:0] f; // Start dir, start phase, dir, phase, switch
    logic exact; // Origin must match exactly
  } ahs_note_type;
  ahs_note_type notes[$]; // Pending expectations
  logic clk, rst_n, cmd, load, move, dir, phase, done;
  logic home_sw, neg_limit, index_pulse;
  logic [5:0] home_mode;
  logic [31:0] load_pos, pos, origin, last_pos;
  int err_total, num_checks;
  // Scene positions: start points and the expected latch points
  localparam logic [31:0] FAR_START = 32'h0000_05DC; // Beyond the cam
  localparam logic [31:0] CAM_START = 32'h0000_041A; // Inside the cam
  localparam logic [31:0] LIM_START = 32'h0000_01F4; // Between limit and cam
  localparam logic [31:0] CAM_IN = 32'h0000_03E8; // First count on the cam
  localparam logic [31:0] CAM_OUT = 32'h0000_03E7; // Last count below it
  localparam logic [31:0] IDX_START = 32'h0000_0834; // Between two marks
  localparam logic [31:0] IDX_LO = 32'h0000_0807; // Last count of lower mark
  localparam logic [31:0] IDX_HI = 32'h0000_0A00; // First count of upper mark

  ahs_axis_homing_sequencer DUT (.CLK(clk), .RST_N(rst_n),
    .HOMING_COMMAND(cmd), .HOME_MODE(home_mode), .AXIS_POS(pos),
    .HOME_SW(home_sw), .NEG_LIMIT(neg_limit), .INDEX_PULSE(index_pulse),
    .MOVE(move), .DIR(dir), .PHASE(phase), .ORIGIN(origin), .DONE(done));
  ahs_axis_model u_axis (.clk(clk), .rst_n(rst_n), .move(move), .dir(dir),
    .phase(phase), .load(load), .load_pos(load_pos), .pos(pos),
    .home_sw(home_sw), .neg_limit(neg_limit), .index_pulse(index_pulse));

  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Origin within a few cycles of travel from the switch or index edge
  function automatic logic near(input logic [31:0] a, input logic [31:0] b);
    near = ((a > b) ? a - b : b - a) <= 32'h0000_0020;
  endfunction

  // Place the axis, note the outcome, command, wait for the result
  task automatic run_home(input logic [5:0] mode, input logic [31:0] start,
                          input logic [31:0] edge_pos, input logic [4:0] f);
    ahs_note_type n;
    int k;
    last_pos = start + $urandom_range(0, 40);
    n.exact = (mode == ahs_pkg::MODE_HERE);
    n.edge_pos = n.exact ? last_pos : edge_pos;
    n.f = f;
    @(posedge clk);
    load <= 1'b1;
    load_pos <= last_pos;
    @(posedge clk);
    load <= 1'b0;
    repeat (6) @(posedge clk);
    notes.push_back(n);
    home_mode <= mode;
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    #1;
    check("done_at_start", 32'(n.exact), 32'(done));
    check("move_at_start", 32'(!n.exact), 32'(move));
    if (!n.exact) begin
      check("dir_at_start", 32'(f[4]), 32'(dir));
      check("phase_at_start", 32'(f[3]), 32'(phase));
    end
    k = 0;
    while (notes.size() != 0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      err_total++;
      $display("[ERR] done expected 1 seen timeout");
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================
  // Clock, watchdog, monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short well past the expected run time
  initial begin
    #900_000;
    err_total++;
    $display("[ERR] run expected finish seen timeout");
    stop_test();
  end

  // Take the oldest note whenever a latch shows up
  initial begin
    ahs_note_type n;
    logic done_p, dir_p, phase_p;
    logic near_ok;
    done_p = 1'b0;
    dir_p = 1'b0;
    phase_p = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (done === 1'b1 && done_p !== 1'b1 && notes.size() != 0) begin
        n = notes.pop_front();
        check("move_after_latch", 32'h0000_0000, 32'(move));
        if (n.exact) begin
          check("origin_exact", n.edge_pos, origin);
        end else begin
          check("dir_before_latch", 32'(n.f[2]), 32'(dir_p));
          check("phase_before_latch", 32'(n.f[1]), 32'(phase_p));
          check("switch_at_latch", 32'(n.f[0]), 32'(home_sw));
          near_ok = near(origin, n.edge_pos);
          check("origin_near", 32'h0000_0001, 32'(near_ok));
        end
      end
      done_p = done;
      dir_p = dir;
      phase_p = phase;
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    cmd = 1'b0;
    load = 1'b0;
    load_pos = 32'h0000_0000;
    home_mode = 6'h0_0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(7));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    run_home(ahs_pkg::MODE_HERE, $urandom(), 32'h0000_0000, 5'b00000);
    // Reserved and unknown modes leave the latched result alone
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      load <= 1'b1;
      load_pos <= last_pos + 32'h0000_0100;
      home_mode <= (i == 0) ? ahs_pkg::MODE_RSVD_A :
                   (i == 1) ? ahs_pkg::MODE_RSVD_B : 6'h0_0;
      cmd <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      cmd <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      check("rsvd_done", 32'h0000_0001, 32'(done));
      check("rsvd_move", 32'h0000_0000, 32'(move));
      check("rsvd_origin", last_pos, origin);
    end
    run_home(ahs_pkg::MODE_SW_NEG_A, FAR_START, CAM_IN, 5'b00111);
    run_home(ahs_pkg::MODE_SW_NEG_A, CAM_START, CAM_IN, 5'b01111);
    run_home(ahs_pkg::MODE_SW_NEG_A, LIM_START, CAM_IN, 5'b00101);
    run_home(ahs_pkg::MODE_SW_NEG_B, FAR_START, CAM_OUT, 5'b00010);
    run_home(ahs_pkg::MODE_SW_NEG_B, CAM_START, CAM_OUT, 5'b01010);
    run_home(ahs_pkg::MODE_SW_NEG_B, LIM_START, CAM_OUT, 5'b00010);
    run_home(ahs_pkg::MODE_IDX_NEG, IDX_START, IDX_LO, 5'b01010);
    run_home(ahs_pkg::MODE_IDX_POS, IDX_START, IDX_HI, 5'b11110);
    stop_test();
  end
endmodule

// ===== verification/ahs_axis_model.sv
// Axis drive model: integrates motion, makes home, limit, index levels.
// Assumes MOVE/DIR/PHASE from the sequencer on the same clock.
`timescale 1ns/1ps

module ahs_axis_model #(
  parameter int HOME_LO = 1000, // Lower edge of the home cam
  parameter int HOME_HI = 1099, // Upper edge of the home cam
  parameter int LIM_AT = 100, // Negative limit on below this
  parameter int FAST = 4, // Counts per cycle, first phase
  parameter int SLOW = 1 // Counts per cycle, second phase
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic move,
  input wire logic dir,
  input wire logic phase,
  input wire logic load, // Place the axis at load_pos
  input wire logic [31:0] load_pos,
  output logic [31:0] pos,
  output logic home_sw,
  output logic neg_limit,
  output logic index_pulse
);
  // ==========================================
  // Motion
  logic [31:0] step; // Counts moved per cycle
  assign step = (phase == ahs_pkg::PHASE_FIRST) ? 32'(FAST) : 32'(SLOW);

  // Integrate position while motion is commanded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 32'h0000_0000;
    end else if (load) begin
      pos <= load_pos;
    end else if (move) begin
      pos <= (dir == ahs_pkg::DIR_POS) ? pos + step : pos - step;
    end
  end

  // ==========================================
  // Sensors
  // Cam is 100 counts wide; index lasts 8 counts, 8 cycles when slow
  assign home_sw = (pos >= 32'(HOME_LO)) && (pos <= 32'(HOME_HI));
  assign neg_limit = pos < 32'(LIM_AT);
  assign index_pulse = pos[8:0] < 9'h008;
endmodule
